// ### common/spu_pkg.sv
// constants, field layouts and states for the serial port block
// Notes on behaviour
// - one synchronous shift mode 0 and three asynchronous modes 1 to 3
// - receive and transmit data registers are separate storage
// - transmitter and receiver are each double-buffered
// - 15-bit bit-rate generator clocked by system clock or external timer pin
// - bit-rate register msb picks clock source, low 15 bits are the divisor
// - transmit pin sends data in async modes, shift clock in mode 0
// - receive pin is async input, or mode 0 data input / open-drain output
// - in modes 1 to 3 any transmit buffer write starts a transmission
// - in mode 0 a transmit write starts only when receiver enable is zero
// - control holds mode, receiver enable, parity enable, ninth transmit bit
// - hardware clears the ninth transmit bit after every finished transmission
// - status holds overrun, tx empty, framing, tx done, rx done, parity/ninth bit
// - reading status clears all flags except transmit empty
// - writing the transmit buffer clears the transmit empty flag
// - separate transmit and receive mask bits gate the serial interrupts
// - separate pending bits set when the transmit or receive event occurs
// - mode 0 gives eight shift clocks and moves eight bits lsb first
// - mode 1 frame: start zero, eight data bits lsb first, stop one
// - modes 2 and 3: start zero, nine data bits lsb first, stop one
// - mode 2 flags reception only if ninth bit is one, mode 3 always
package spu_pkg;
  localparam logic [15:0] OFS_RX_BUF  = 16'h1fb8;
  localparam logic [15:0] OFS_STATUS  = 16'h1fb9;
  localparam logic [15:0] OFS_TX_BUF  = 16'h1fba;
  localparam logic [15:0] OFS_CONTROL = 16'h1fbb;
  localparam logic [15:0] OFS_BITRATE = 16'h1fbc;
  localparam logic [15:0] OFS_IRQ     = 16'h1fc0;
  // control fields
  localparam int CON_MODE_LO = 0;
  localparam int CON_PAR     = 2;
  localparam int CON_REN     = 3;
  localparam int CON_TB8     = 4;
  // status fields
  localparam int ST_OE  = 2;
  localparam int ST_TXE = 3;
  localparam int ST_FE  = 4;
  localparam int ST_TI  = 5;
  localparam int ST_RI  = 6;
  localparam int ST_RB8 = 7;
  // irq register fields: mask tx, mask rx, pend tx, pend rx
  localparam int IRQ_MTX = 0;
  localparam int IRQ_MRX = 1;
  localparam int IRQ_PTX = 2;
  localparam int IRQ_PRX = 3;
  localparam int BIT_SRC = 15;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] OVERSAMPLE = 4'hf;
  localparam logic [3:0] NBITS_M0   = 4'h8;
  localparam logic [3:0] NBITS_M1   = 4'ha;
  localparam logic [3:0] NBITS_M23  = 4'hb;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} spu_tx_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SHIFT = 2'b01} spu_rx_t;
endpackage

// ### rtl/spu_serial_port.sv
// serial port: apb registers, bit-rate generator, transmitter and receiver
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
module spu_serial_port
  import spu_pkg::*;
#(
  parameter int DIV_W = 15              // bit-rate divisor width
)(
  input  wire logic        sys_clk,     // 10 MHz system clock
  input  wire logic        sys_rst,     // synchronous reset, high
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [15:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  input  wire logic        extTimerClockPin, // external bit-rate clock pin
  output logic             txPin,       // serial data, or mode 0 shift clock
  input  wire logic        rxPinIn,     // receive pin level
  output logic             rxPinOut,    // receive pin drive, mode 0
  output logic             rxPinOe,     // receive pin open-drain enable
  output logic             txIrq,       // masked transmit interrupt request
  output logic             rxIrq        // masked receive interrupt request
);
  initial
  begin
    if (DIV_W != 15) $error("divisor width must be 15");
  end

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  control;
    logic [15:0] bitRate;
    logic [7:0]  status;
    logic [3:0]  irq;
    logic [7:0]  rxBuf;
    logic        rxUnread;
    logic [8:0]  txHold;
    logic        txFull;
    logic [14:0] divCnt;
    logic [3:0]  tick16;
    logic [1:0]  extSync;
    logic        extPrev;
    logic [1:0]  rxSync;
    logic        rxPrev;
    spu_tx_t     txState;
    logic [10:0] txShift;
    logic [3:0]  txBits;
    logic [3:0]  txPhase;
    logic        txPin;
    spu_rx_t     rxState;
    logic [9:0]  rxShift;
    logic [3:0]  rxBits;
    logic [3:0]  rxPhase;
    logic        rxOut;
    logic        rxOe;
    logic        txIrq;
    logic        rxIrq;
  } spu_state_t;

  spu_state_t st;
  spu_state_t next_st;

  logic [1:0] mode;
  logic       wrAcc;
  logic       rdAcc;
  logic       extRise;
  logic       genTick;
  logic       bitTick;
  logic       rxLevel;
  logic       parBit;
  logic       rxDone9;
  logic       rxGood;
  logic       txLoad;
  logic [15:0] regIdx;

  assign mode    = st.control[CON_MODE_LO +: 2];
  assign wrAcc   = psel && penable && pwrite && st.pready;
  assign rdAcc   = psel && penable && !pwrite && st.pready;
  assign rxLevel = st.rxSync[1];
  assign extRise = st.extSync[1] && !st.extPrev;
  assign parBit  = ^st.txHold[7:0];
  // registers sit one per word: the byte address is four times the register index
  assign regIdx  = {2'h0, paddr[15:2]};

  ////////////////////////////////////////////////////////////////////////
  // one process builds the whole next state
  always_comb
  begin
    next_st = st;
    genTick = 1'b0;
    bitTick = 1'b0;
    rxDone9 = 1'b0;
    rxGood  = 1'b0;
    txLoad  = 1'b0;
    // pin synchronisers: first stage only feeds the second
    next_st.extSync = {st.extSync[0], extTimerClockPin};
    next_st.rxSync  = {st.rxSync[0], rxPinIn};
    next_st.extPrev = st.extSync[1];
    next_st.rxPrev  = rxLevel;

    // bit-rate generator, source picked by msb of divisor register
    if (!st.bitRate[BIT_SRC] || extRise)
    begin
      if (st.divCnt == '0)
      begin
        next_st.divCnt = st.bitRate[DIV_W-1:0];
        genTick        = 1'b1;
      end
      else
        next_st.divCnt = st.divCnt - 15'h0001;
    end
    if (genTick)
      next_st.tick16 = st.tick16 + 4'h1;
    bitTick = genTick && (st.tick16 == OVERSAMPLE);

    // apb slave: one wait state, pready pulses in the access phase
    next_st.pready  = psel && penable && !st.pready;
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready)
    begin
      next_st.prdata = '0;
      unique case (regIdx)
        OFS_RX_BUF:  next_st.prdata = {24'h0, st.rxBuf};
        OFS_STATUS:  next_st.prdata = {24'h0, st.status};
        OFS_CONTROL: next_st.prdata = {24'h0, st.control};
        OFS_BITRATE: next_st.prdata = {16'h0, st.bitRate};
        OFS_IRQ:     next_st.prdata = {28'h0, st.irq};
        OFS_TX_BUF:  next_st.prdata = '0;
        default:     next_st.pslverr = 1'b1;
      endcase
    end
    if (rdAcc && regIdx == OFS_RX_BUF)
      next_st.rxUnread = 1'b0;
    if (rdAcc && regIdx == OFS_STATUS)
      next_st.status = st.status & (8'h01 << ST_TXE);
    if (wrAcc)
    begin
      case (regIdx)
        OFS_CONTROL: next_st.control = pwdata[7:0];
        OFS_BITRATE: next_st.bitRate = pwdata[15:0];
        OFS_IRQ:     next_st.irq     = pwdata[3:0];
        OFS_TX_BUF:
        begin
          // mode 0 only sends with the receiver off
          if (mode != 2'h0 || !st.control[CON_REN])
          begin
            next_st.txHold = {st.control[CON_TB8], pwdata[7:0]};
            next_st.txFull = 1'b1;
            next_st.status[ST_TXE] = 1'b0;
            txLoad = 1'b1;
          end
        end
        default: next_st.pslverr = 1'b0;
      endcase
    end

    // transmitter: holding register feeds shifter; the next frame starts one idle bit after the stop bit
    case (st.txState)
      TX_IDLE:
      begin
        next_st.txPin = 1'b1;
        if (st.txFull && bitTick)
        begin
          // a write in this same cycle refills the holding register, so it stays full
          next_st.txFull = txLoad;
          next_st.status[ST_TXE] = !txLoad;
          next_st.txBits = '0;
          next_st.txState = TX_SHIFT;
          // parity replaces bit 7 in mode 1, bit 8 in mode 3
          if (mode == 2'h0)
            next_st.txShift = {3'h7, st.txHold[7:0]};
          else if (mode == 2'h1)
            next_st.txShift = {2'h3, st.control[CON_PAR] ? parBit : st.txHold[7],
                               st.txHold[6:0], 1'b0};
          else
            next_st.txShift = {1'b1, (mode == 2'h3 && st.control[CON_PAR])
                               ? parBit : st.txHold[8], st.txHold[7:0], 1'b0};
          if (mode == 2'h0)
          begin
            next_st.rxOe  = !st.txHold[0];
            next_st.rxOut = 1'b0;
          end
        end
      end
      TX_SHIFT:
      begin
        if (mode == 2'h0)
        begin
          // shift clock low in first half of each bit on the transmit pin
          if (genTick)
            next_st.txPin = st.tick16[3];
          if (bitTick)
          begin
            next_st.txShift = {1'b1, st.txShift[10:1]};
            next_st.txBits  = st.txBits + 4'h1;
            next_st.rxOe    = !st.txShift[1];
            if (st.txBits == NBITS_M0 - 4'h1)
            begin
              next_st.rxOe = 1'b0;
              next_st.txState = TX_IDLE;
              next_st.status[ST_TI] = 1'b1;
              next_st.irq[IRQ_PTX] = 1'b1;
              next_st.control[CON_TB8] = 1'b0;
            end
          end
        end
        else
        begin
          next_st.txPin = st.txShift[0];
          if (bitTick)
          begin
            next_st.txShift = {1'b1, st.txShift[10:1]};
            next_st.txBits  = st.txBits + 4'h1;
            if (st.txBits == ((mode == 2'h1) ? NBITS_M1 : NBITS_M23) - 4'h2)
            begin
              next_st.status[ST_TI] = 1'b1;                    // stop bit begins
              next_st.irq[IRQ_PTX] = 1'b1;
            end
            if (st.txBits == ((mode == 2'h1) ? NBITS_M1 : NBITS_M23) - 4'h1)
            begin
              next_st.txState = TX_IDLE;
              next_st.control[CON_TB8] = 1'b0;
            end
          end
        end
      end
      default: next_st.txState = TX_IDLE;
    endcase

    // receiver: start-bit edge restarts the phase counter
    case (st.rxState)
      RX_IDLE:
      begin
        next_st.rxPhase = '0;
        next_st.rxBits  = '0;
        if (st.control[CON_REN] && mode != 2'h0 && st.rxPrev && !rxLevel)
          next_st.rxState = RX_SHIFT;
        else if (st.control[CON_REN] && mode == 2'h0 && !st.rxPrev && rxLevel
                 && st.txState == TX_IDLE)
          next_st.rxState = RX_SHIFT;
      end
      RX_SHIFT:
      begin
        if (!st.control[CON_REN])
          next_st.rxState = RX_IDLE;                           // disabling stops it
        else if (genTick)
        begin
          next_st.rxPhase = st.rxPhase + 4'h1;
          if (mode == 2'h0)
            next_st.txPin = st.rxPhase[3];
          if (st.rxPhase == SAMPLE_MID)
          begin
            next_st.rxShift = {rxLevel, st.rxShift[9:1]};
            next_st.rxBits  = st.rxBits + 4'h1;
            if ((mode == 2'h0 && st.rxBits == NBITS_M0 - 4'h1) ||
                (mode == 2'h1 && st.rxBits == NBITS_M1 - 4'h1) ||
                (mode[1] && st.rxBits == NBITS_M23 - 4'h1))
            begin
              next_st.rxState = RX_IDLE;
              next_st.txPin = 1'b1;
              rxDone9 = 1'b1;
            end
          end
        end
      end
      default: next_st.rxState = RX_IDLE;
    endcase

    // completed frame lands in the receive buffer, except a mode 2 frame whose ninth bit is zero
    if (rxDone9)
    begin
      rxGood = (mode != 2'h2) || st.rxShift[9];
      if (rxGood)
      begin
        next_st.status[ST_OE] = st.status[ST_OE] || st.rxUnread;
        next_st.rxUnread = 1'b1;
        next_st.status[ST_RI] = 1'b1;
        next_st.irq[IRQ_PRX] = 1'b1;
        if (mode == 2'h0)
          next_st.rxBuf = {rxLevel, st.rxShift[9:3]};
        else if (mode == 2'h1)
        begin
          next_st.rxBuf = st.rxShift[9:2];
          next_st.status[ST_FE] = st.status[ST_FE] || !rxLevel;
          if (st.control[CON_PAR])
            next_st.status[ST_RB8] = ^st.rxShift[9:2];
        end
        else
        begin
          next_st.rxBuf = st.rxShift[8:1];
          next_st.status[ST_FE] = st.status[ST_FE] || !rxLevel;
          next_st.status[ST_RB8] = (mode == 2'h3 && st.control[CON_PAR])
                                   ? ^st.rxShift[9:1] : st.rxShift[9];
        end
      end
    end

    next_st.txIrq = st.irq[IRQ_PTX] && st.irq[IRQ_MTX];
    next_st.rxIrq = st.irq[IRQ_PRX] && st.irq[IRQ_MRX];

    if (sys_rst)
    begin
      next_st = '0;
      next_st.status[ST_TXE] = 1'b1;
      next_st.txPin = 1'b1;
      next_st.extPrev = 1'b0;
      next_st.rxPrev = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the only clocked process
  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign txPin    = st.txPin;
  assign rxPinOut = st.rxOut;
  assign rxPinOe  = st.rxOe;
  assign txIrq    = st.txIrq;
  assign rxIrq    = st.rxIrq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_txe_clear_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wrAcc && regIdx == OFS_TX_BUF && mode != 2'h0 |=> !st.status[ST_TXE])
    else $error("tx empty not cleared by write");
  a_status_read_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rdAcc && regIdx == OFS_STATUS && !rxDone9
    |=> !st.status[ST_FE] && !st.status[ST_OE] && !st.status[ST_RI])
    else $error("status read did not clear");
  a_mode0_blocked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wrAcc && regIdx == OFS_TX_BUF && mode == 2'h0 && st.control[CON_REN] && !st.txFull
    |=> !st.txFull) else $error("mode 0 write started with receiver on");
  a_rxpend_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxGood |=> st.irq[IRQ_PRX]) else $error("rx pending not set");
  a_mode2_filter: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxDone9 && mode == 2'h2 && !st.rxShift[9] |-> !rxGood)
    else $error("mode 2 accepted frame with ninth bit zero");
  a_overrun_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxGood && st.rxUnread |=> st.status[ST_OE]) else $error("overrun missed");
  a_tb8_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.txState == TX_SHIFT ##1 st.txState == TX_IDLE && !$past(wrAcc) |-> !st.control[CON_TB8])
    else $error("ninth tx bit not cleared");
  a_irq_mask_tx: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st.irq[IRQ_MTX] ##1 !st.irq[IRQ_MTX] |-> !txIrq) else $error("masked tx irq");
endmodule

// ### testbench/spu_far_device.sv
// far-side serial device: async frame sender, frame decoder, shift clock counter
`timescale 1ns/100ps
module spu_far_device #(
  parameter int BIT_NS = 1600           // bit time: 16 ticks at divisor 0
)(
  input  wire logic       txPin,        // device serial output
  input  wire logic       frameOn,      // decode async frames on txPin
  input  wire logic [3:0] nData,        // data bits per frame
  output logic            farDrive,     // line drive, 1 releases to idle high
  output logic      [8:0] gotData,      // data of the last frame, lsb first
  output logic            gotStop,      // stop level of the last frame
  output int              gotCount,     // frames decoded so far
  output int              edgeCount     // rising edges seen on txPin
);
  initial
  begin
    farDrive = 1'h1;
    gotData = 9'h0;
    gotStop = 1'h0;
    gotCount = 0;
    edgeCount = 0;
  end

  // shift clock pulses, counted by the bench around mode 0 transfers
  always @(posedge txPin)
    edgeCount <= edgeCount + 1;

  // sample mid-bit; a dip shorter than half a bit is not taken as a start
  always @(negedge txPin)
  begin
    if (frameOn)
    begin
      #(BIT_NS / 2);
      if (txPin === 1'h0)
      begin
        gotData = 9'h0;
        for (int i = 0; i < nData; i++)
        begin
          #(BIT_NS);
          gotData[i] = txPin;
        end
        #(BIT_NS);
        gotStop = txPin;
        gotCount++;
      end
    end
  end

  // one frame, then a bit of idle so the receiver sees a clean stop
  task automatic send(input logic [8:0] data, input int n, input logic stop);
    farDrive = 1'h0;
    #(BIT_NS);
    for (int i = 0; i < n; i++)
    begin
      farDrive = data[i];
      #(BIT_NS);
    end
    farDrive = stop;
    #(BIT_NS);
    farDrive = 1'h1;
    #(BIT_NS);
  endtask
endmodule

// ### testbench/serial_port_uart_bench.sv
// self-checking bench for the serial port block
`timescale 1ns/100ps
module serial_port_uart_bench
  import spu_pkg::*;
;
  localparam logic [31:0] mOver = 32'h1 << ST_OE;
  localparam logic [31:0] mTxEmpty = 32'h1 << ST_TXE;
  localparam logic [31:0] mTxDone = 32'h1 << ST_TI;
  localparam logic [31:0] mRxDone = 32'h1 << ST_RI;
  localparam logic [31:0] mNinth = 32'h1 << ST_RB8;
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic        extClk = 1'h0;           // held: generator runs from sys_clk
  logic        frameOn = 1'h0;
  logic [3:0]  nData = 4'h8;
  logic [31:0] prdata;
  logic        pready, pslverr, txPin, rxPinOut, rxPinOe, txIrq, rxIrq;
  logic        farDrive, rxLine, gotStop, errBit;
  logic [8:0]  gotData;
  logic [31:0] v;
  int          gotCount, edgeCount, n0, k;
  int          error_cnt = 0;
  int          checks = 0;

  always #50 sys_clk = ~sys_clk;

  // wired line with pull-up: device pulls low only when its enable is on
  assign rxLine = farDrive & ~(rxPinOe & ~rxPinOut);

  spu_serial_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .extTimerClockPin(extClk),
    .txPin(txPin), .rxPinIn(rxLine), .rxPinOut(rxPinOut), .rxPinOe(rxPinOe),
    .txIrq(txIrq), .rxIrq(rxIrq));

  spu_far_device far (.txPin(txPin), .frameOn(frameOn), .nData(nData),
    .farDrive(farDrive), .gotData(gotData), .gotStop(gotStop),
    .gotCount(gotCount), .edgeCount(edgeCount));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fail(input string what);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, what);
    test_done();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; word index -> byte address
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'h0};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
      fail("no apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, idx, d, r, e);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic waitfr(input int n);
    int t;
    t = 0;
    while (gotCount < n && t < 4000)
    begin
      @(posedge sys_clk);
      t++;
    end
    if (gotCount < n)
      fail("frame missing");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // register map, mode 1 traffic, nine-bit modes, interrupt gating, mode 0
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    rdc(OFS_STATUS, mTxEmpty);
    rdc(OFS_CONTROL, 32'h0);
    apb(1'h0, 16'h1fbe, 32'h0, v, errBit);
    chk({31'h0, errBit}, 32'h1);
    wr(OFS_BITRATE, 32'hffff);
    rdc(OFS_BITRATE, 32'hffff);
    wr(OFS_BITRATE, 32'h0);
    frameOn <= 1'h1;
    wr(OFS_CONTROL, 32'h9);
    rdc(OFS_CONTROL, 32'h9);
    wr(OFS_TX_BUF, 32'ha5);
    repeat (40) @(posedge sys_clk);
    wr(OFS_TX_BUF, 32'h3c);
    rdc(OFS_STATUS, 32'h0);
    waitfr(1);
    chk({22'h0, gotStop, gotData}, 32'h2a5);
    waitfr(2);
    chk({22'h0, gotStop, gotData}, 32'h23c);
    rdc(OFS_STATUS, mTxEmpty | mTxDone);
    rdc(OFS_STATUS, mTxEmpty);
    far.send(9'h05a, 8, 1'h1);
    @(posedge sys_clk);
    rdc(OFS_RX_BUF, 32'h5a);
    rdc(OFS_STATUS, mTxEmpty | mRxDone);
    far.send(9'h011, 8, 1'h1);
    far.send(9'h022, 8, 1'h1);
    @(posedge sys_clk);
    rdc(OFS_STATUS, mTxEmpty | mRxDone | mOver);
    rdc(OFS_RX_BUF, 32'h22);
    far.send(9'h000, 8, 1'h0);
    @(posedge sys_clk);
    apb(1'h0, OFS_STATUS, 32'h0, v, errBit);
    chk({31'h0, v[ST_FE]}, 32'h1);
    apb(1'h0, OFS_RX_BUF, 32'h0, v, errBit);
    nData <= 4'h9;
    wr(OFS_CONTROL, 32'h1b);
    wr(OFS_TX_BUF, 32'h81);
    waitfr(3);
    chk({23'h0, gotData}, 32'h181);
    repeat (16) @(posedge sys_clk);
    rdc(OFS_CONTROL, 32'hb);
    apb(1'h0, OFS_STATUS, 32'h0, v, errBit);
    wr(OFS_CONTROL, 32'ha);
    wr(OFS_IRQ, 32'h2);
    far.send(9'h033, 9, 1'h1);
    @(posedge sys_clk);
    chk({31'h0, rxIrq}, 32'h0);
    rdc(OFS_STATUS, mTxEmpty);
    far.send(9'h144, 9, 1'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, rxIrq}, 32'h1);
    rdc(OFS_IRQ, 32'ha);
    rdc(OFS_STATUS, mTxEmpty | mRxDone | mNinth);
    rdc(OFS_RX_BUF, 32'h44);
    wr(OFS_IRQ, 32'h8);
    @(posedge sys_clk);
    chk({31'h0, rxIrq}, 32'h0);
    wr(OFS_IRQ, 32'h0);
    wr(OFS_CONTROL, 32'hb);
    far.send(9'h055, 9, 1'h1);
    @(posedge sys_clk);
    rdc(OFS_STATUS, mTxEmpty | mRxDone);
    rdc(OFS_RX_BUF, 32'h55);
    frameOn <= 1'h0;
    wr(OFS_CONTROL, 32'h0);
    n0 = edgeCount;
    wr(OFS_TX_BUF, 32'h96);
    k = 0;
    v = 32'h0;
    while (v[ST_TI] !== 1'h1 && k < 200)
    begin
      apb(1'h0, OFS_STATUS, 32'h0, v, errBit);
      k++;
    end
    if (v[ST_TI] !== 1'h1)
      fail("no mode 0 tx done");
    chk(32'(edgeCount - n0), 32'h8);
    wr(OFS_CONTROL, 32'h8);
    n0 = edgeCount;
    wr(OFS_TX_BUF, 32'h69);
    repeat (300) @(posedge sys_clk);
    chk(32'(edgeCount - n0), 32'h0);
    test_done();
  end
endmodule
